// *** hdl/pcxio_top.sv ***
// Priority crossbar and port I/O configuration block with an APB register slave.
//
// Notes on behaviour
// (R1) Seventeen pins: two byte ports and one single-bit port; first two crossbar-assignable.
// (R2) Enabled resources after the UART, in priority order, take lowest free pin.
// (R3) UART transmit always on port 0 pin 4, receive on pin 5.
// (R4) Crossbar passes over pins whose skip bit is set.
// (R5) Skipped pin is treated like an assigned pin; next resource moves on.
// (R6) SMBus enable claims two pins; UART enable claims both its pins.
// (R7) Leftover pins stay general-purpose I/O after the assigned functions.
// (R8) SPI slave select gets a pin only in four-wire mode.
// (R9) Input mode bit 1 selects digital input, 0 selects analog.
// (R10) Analog pins lose weak pullup, output driver and input receiver.
// (R11) After reset every pin is in digital input mode.
// (R12) Output mode bit picks open-drain or push-pull, also for peripheral pins.
// (R13) SMBus data and clock pins always drive open-drain.
// (R14) Weak pullup on every open-drain pin while pullup disable bit is 0.
// (R15) Weak pullup is off on any pin currently driving low.
// (R16) Crossbar enable bit 1 enables routing; disabled means plain input port pins.
// (R17) All output drivers off while the crossbar is disabled.
// (R18) Port register reads return pin state regardless of routing.
// (R19) Software sets input modes, output modes, skips, routes, then crossbar enable.
// (R20) Software skips pins used by functions outside the crossbar.
// (R21) Software puts converter and comparator inputs analog and skipped.
// (R22) Counter-array field routes zero, one, two or three module pins.
// (R23) Analog pins read 0; open-drain latch 1 leaves pin high impedance.
// (R24) Assignments recomputed from settings, taking effect on the next clock.
`timescale 1ns/10ps
`default_nettype none

module pcxio_top
  import pcxio_pkg::*;
(
  // Clock and reset.
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave.
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Peripheral side, one bit per signal in priority order.
  input  wire logic [NUM_SIGS-1:0]  periph_out,
  input  wire logic [NUM_SIGS-1:0]  periph_drive,
  output logic      [NUM_SIGS-1:0]  periph_in,
  // Pin side, port 0 in bits 7:0, port 1 in 15:8, port 2 in bit 16.
  input  wire logic [NUM_PINS-1:0]  pin_in,
  output logic      [NUM_PINS-1:0]  pin_out,
  output logic      [NUM_PINS-1:0]  pin_oe,
  output logic      [NUM_PINS-1:0]  pin_pullup
);

  // Configuration registers.
  logic [5:0]           peripheral_route_reg_a_q;
  logic [7:0]           peripheral_route_reg_b_q;
  logic [7:0]           port0_latch_q;
  logic [7:0]           port1_latch_q;
  logic                 port2_latch_q;
  logic [7:0]           port0_input_mode_q;
  logic [7:0]           port1_input_mode_q;
  logic [7:0]           port0_output_mode_q;
  logic [7:0]           port1_output_mode_q;
  logic [7:0]           port0_skip_mask_q;
  logic [7:0]           port1_skip_mask_q;
  logic [1:0]           spi_select_mode_field_q;
  logic [1:0]           port2_mode_q;

  // Derived control.
  logic                 crossbar_enable_bit;
  logic                 weak_pullup_disable;
  logic [1:0]           counter_array_io_enable;
  logic [NUM_SIGS-1:0]  sig_en;
  logic [NUM_PINS-1:0]  pin_input_mode_mask;
  logic [NUM_PINS-1:0]  pin_output_mode_mask;
  logic [NUM_PINS-1:0]  pin_latch;
  logic [XBAR_PINS-1:0] pin_skip_mask;

  // Pin assignment map.
  logic [NUM_PINS-1:0]  pin_used_d;
  logic [NUM_PINS-1:0]  pin_used_q;
  logic [4:0]           pin_sig_d [NUM_PINS];
  logic [4:0]           pin_sig_q [NUM_PINS];

  // Input synchronisers and filtered pin state.
  logic [NUM_PINS-1:0]  pin_s1_q;
  logic [NUM_PINS-1:0]  pin_s2_q;
  logic [NUM_PINS-1:0]  pin_s3_q;
  logic [NUM_PINS-1:0]  pin_state_q;
  logic [NUM_PINS-1:0]  pin_read;

  // Peripheral input return path.
  logic [NUM_SIGS-1:0]  periph_in_d;
  logic [NUM_SIGS-1:0]  periph_in_q;

  // Bus decode.
  logic                 setup_phase;
  logic                 access_phase;
  logic                 wr_en;
  logic [31:0]          rd_d;
  logic [31:0]          prdata_q;

  // True when the offset names a mapped register.
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == OFF_ROUTE_A)  || (a == OFF_ROUTE_B)  || (a == OFF_PORT0)    ||
               (a == OFF_PORT1)    || (a == OFF_PORT2)    || (a == OFF_P0_INMD)  ||
               (a == OFF_P1_INMD)  || (a == OFF_P0_OUTMD) || (a == OFF_P1_OUTMD) ||
               (a == OFF_P0_SKIP)  || (a == OFF_P1_SKIP)  || (a == OFF_SPI_MODE) ||
               (a == OFF_P2_MODE);
  endfunction

  // True when the signal index is one of the two SMBus lines.
  function automatic logic is_smbus(input logic [4:0] s);
    is_smbus = (s == SIG_SDA) || (s == SIG_SCL);
  endfunction

  // Phase decode of the APB transfer.
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_en        = access_phase & pwrite & addr_hit(paddr);

  // The answer comes in the access cycle; read data was captured in setup.
  assign pready  = access_phase;
  assign pslverr = access_phase & ~addr_hit(paddr);
  assign prdata  = prdata_q;

  // Register writes take effect at the access edge only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_route_reg_a_q <= RST_ROUTE_A;
      peripheral_route_reg_b_q <= RST_ROUTE_B;
      port0_latch_q            <= RST_LATCH;
      port1_latch_q            <= RST_LATCH;
      port2_latch_q            <= RST_LATCH[0];
      port0_input_mode_q       <= RST_INMD;  // R11
      port1_input_mode_q       <= RST_INMD;  // R11
      port0_output_mode_q      <= RST_OUTMD;
      port1_output_mode_q      <= RST_OUTMD;
      port0_skip_mask_q        <= RST_SKIP;
      port1_skip_mask_q        <= RST_SKIP;
      spi_select_mode_field_q  <= RST_SPIMD;
      port2_mode_q             <= RST_P2MODE;  // R11
    end else if (wr_en) begin
      if (paddr == OFF_ROUTE_A) begin
        peripheral_route_reg_a_q <= pwdata[5:0];
      end else if (paddr == OFF_ROUTE_B) begin
        peripheral_route_reg_b_q <= {pwdata[7:3], 1'b0, pwdata[1:0]};
      end else if (paddr == OFF_PORT0) begin
        port0_latch_q <= pwdata[7:0];
      end else if (paddr == OFF_PORT1) begin
        port1_latch_q <= pwdata[7:0];
      end else if (paddr == OFF_PORT2) begin
        port2_latch_q <= pwdata[0];
      end else if (paddr == OFF_P0_INMD) begin
        port0_input_mode_q <= pwdata[7:0];
      end else if (paddr == OFF_P1_INMD) begin
        port1_input_mode_q <= pwdata[7:0];
      end else if (paddr == OFF_P0_OUTMD) begin
        port0_output_mode_q <= pwdata[7:0];
      end else if (paddr == OFF_P1_OUTMD) begin
        port1_output_mode_q <= pwdata[7:0];
      end else if (paddr == OFF_P0_SKIP) begin
        port0_skip_mask_q <= pwdata[7:0];
      end else if (paddr == OFF_P1_SKIP) begin
        port1_skip_mask_q <= pwdata[7:0];
      end else if (paddr == OFF_SPI_MODE) begin
        spi_select_mode_field_q <= pwdata[1:0];
      end else if (paddr == OFF_P2_MODE) begin
        port2_mode_q <= pwdata[1:0];
      end
    end
  end

  // Read multiplexer; port registers show the filtered pin state.
  always_comb begin
    rd_d = 32'h0000_0000;
    if (paddr == OFF_ROUTE_A) begin
      rd_d[5:0] = peripheral_route_reg_a_q;
    end else if (paddr == OFF_ROUTE_B) begin
      rd_d[7:0] = peripheral_route_reg_b_q;
    end else if (paddr == OFF_PORT0) begin
      rd_d[7:0] = pin_read[7:0];  // R18
    end else if (paddr == OFF_PORT1) begin
      rd_d[7:0] = pin_read[15:8];  // R18
    end else if (paddr == OFF_PORT2) begin
      rd_d[0] = pin_read[16];  // R18
    end else if (paddr == OFF_P0_INMD) begin
      rd_d[7:0] = port0_input_mode_q;
    end else if (paddr == OFF_P1_INMD) begin
      rd_d[7:0] = port1_input_mode_q;
    end else if (paddr == OFF_P0_OUTMD) begin
      rd_d[7:0] = port0_output_mode_q;
    end else if (paddr == OFF_P1_OUTMD) begin
      rd_d[7:0] = port1_output_mode_q;
    end else if (paddr == OFF_P0_SKIP) begin
      rd_d[7:0] = port0_skip_mask_q;
    end else if (paddr == OFF_P1_SKIP) begin
      rd_d[7:0] = port1_skip_mask_q;
    end else if (paddr == OFF_SPI_MODE) begin
      rd_d[1:0] = spi_select_mode_field_q;
    end else if (paddr == OFF_P2_MODE) begin
      rd_d[1:0] = port2_mode_q;
    end
  end

  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata_q <= rd_d;
    end
  end

  // Flatten the per-port settings into per-pin vectors.
  assign crossbar_enable_bit     = peripheral_route_reg_b_q[RB_CROSSBAR_ENABLE_BIT];
  assign weak_pullup_disable     = peripheral_route_reg_b_q[RB_WPUD];
  assign counter_array_io_enable = peripheral_route_reg_b_q[RB_PCA_LO +: 2];
  assign pin_input_mode_mask     = {port2_mode_q[P2_INMD], port1_input_mode_q,
                                    port0_input_mode_q};  // R1
  assign pin_output_mode_mask    = {port2_mode_q[P2_OUTMD], port1_output_mode_q,
                                    port0_output_mode_q};
  assign pin_latch               = {port2_latch_q, port1_latch_q, port0_latch_q};
  assign pin_skip_mask           = {port1_skip_mask_q, port0_skip_mask_q};

  // Enable of each peripheral signal from the routing fields.
  always_comb begin
    sig_en           = '0;
    sig_en[SIG_TX]   = peripheral_route_reg_a_q[RA_UART];  // R6
    sig_en[SIG_RX]   = peripheral_route_reg_a_q[RA_UART];  // R6
    sig_en[SIG_SCK]  = peripheral_route_reg_a_q[RA_SPI];
    sig_en[SIG_MISO] = peripheral_route_reg_a_q[RA_SPI];
    sig_en[SIG_MOSI] = peripheral_route_reg_a_q[RA_SPI];
    sig_en[SIG_NSS]  = peripheral_route_reg_a_q[RA_SPI] &
                       (spi_select_mode_field_q != SPI_3WIRE);  // R8
    sig_en[SIG_SDA]  = peripheral_route_reg_a_q[RA_SMB];  // R6
    sig_en[SIG_SCL]  = peripheral_route_reg_a_q[RA_SMB];  // R6
    sig_en[SIG_CP]   = peripheral_route_reg_a_q[RA_CP];
    sig_en[SIG_CPA]  = peripheral_route_reg_a_q[RA_CPA];
    sig_en[SIG_SYSC] = peripheral_route_reg_a_q[RA_SYSC];
    sig_en[SIG_COUNTER_MODULE0_IO] = (counter_array_io_enable != 2'h0);  // R22
    sig_en[SIG_CEX1] = counter_array_io_enable[1];  // R22
    sig_en[SIG_CEX2] = (counter_array_io_enable == 2'h3);  // R22
    sig_en[SIG_ECI]  = peripheral_route_reg_b_q[RB_ECI];
    sig_en[SIG_T0]   = peripheral_route_reg_b_q[RB_T0];
    sig_en[SIG_T1]   = peripheral_route_reg_b_q[RB_T1];
  end

  // Priority decoder: UART on its fixed pins, then walk the other signals in order and give each the lowest free pin.
  always_comb begin
    logic [XBAR_PINS-1:0] taken;
    logic                 found;
    taken = pin_skip_mask;  // R4 R5
    found = 1'b0;
    pin_used_d = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_sig_d[p] = 5'h00;
    end
    if (sig_en[SIG_TX]) begin
      taken[UART_TX_PIN]      = 1'b1;  // R3
      taken[UART_RX_PIN]      = 1'b1;  // R3
      pin_used_d[UART_TX_PIN] = 1'b1;
      pin_used_d[UART_RX_PIN] = 1'b1;
      pin_sig_d[UART_TX_PIN]  = SIG_TX;
      pin_sig_d[UART_RX_PIN]  = SIG_RX;
    end
    for (int s = int'(SIG_SCK); s < NUM_SIGS; s++) begin
      found = 1'b0;
      if (sig_en[s]) begin
        for (int p = 0; p < XBAR_PINS; p++) begin
          if (!found && !taken[p]) begin
            taken[p]      = 1'b1;  // R2 R5
            found         = 1'b1;
            pin_used_d[p] = 1'b1;
            pin_sig_d[p]  = 5'(s);  // R2
          end
        end
      end
    end
  end

  // The map is re-registered every clock so new settings apply one edge later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_used_q <= '0;
      for (int p = 0; p < NUM_PINS; p++) begin
        pin_sig_q[p] <= 5'h00;
      end
    end else begin
      pin_used_q <= pin_used_d;  // R24 R7
      for (int p = 0; p < NUM_PINS; p++) begin
        pin_sig_q[p] <= pin_sig_d[p];  // R24
      end
    end
  end

  // Pin inputs pass three flip-flops; a change counts once stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q    <= '0;
      pin_s2_q    <= '0;
      pin_s3_q    <= '0;
      pin_state_q <= '0;
    end else begin
      pin_s1_q    <= pin_in;
      pin_s2_q    <= pin_s1_q;
      pin_s3_q    <= pin_s2_q;
      pin_state_q <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) |
                     (pin_state_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  // Analog pins have their receiver off and read as zero.
  assign pin_read = pin_state_q & pin_input_mode_mask;  // R9 R10 R23

  // Route each assigned pin's level back to its peripheral; idle lines read high.
  always_comb begin
    periph_in_d = '1;
    for (int p = 0; p < XBAR_PINS; p++) begin
      if (crossbar_enable_bit && pin_used_q[p]) begin
        periph_in_d[pin_sig_q[p]] = pin_read[p];  // R16
      end
    end
  end

  // Register the peripheral inputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_in_q <= '1;
    end else begin
      periph_in_q <= periph_in_d;
    end
  end

  assign periph_in = periph_in_q;

  // Per-pin driver, output mode and weak pullup control.
  generate
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      logic       routed;
      logic       open_drain;
      logic       drv_val;
      logic       drv_req;
      logic       oe_c;
      logic       out_c;
      logic       pu_c;
      logic       out_q;
      logic       oe_q;
      logic       pu_q;
      logic [4:0] sig;

      // Peripheral signal on this pin, only while the crossbar is on.
      assign sig    = pin_sig_q[p];
      assign routed = crossbar_enable_bit & pin_used_q[p];  // R16

      // SMBus lines are forced open-drain; all others follow their mode bit.
      assign open_drain = ~pin_output_mode_mask[p] | (routed & is_smbus(sig));  // R12 R13

      // Data source: the peripheral when routed, else the port latch.
      assign drv_val = routed ? periph_out[sig] : pin_latch[p];  // R7
      assign drv_req = routed ? periph_drive[sig] : 1'b1;

      // Driver: off when analog or crossbar disabled; open-drain only pulls low.
      always_comb begin
        oe_c  = 1'b0;
        out_c = 1'b0;
        if (!pin_input_mode_mask[p] || !crossbar_enable_bit) begin
          oe_c  = 1'b0;  // R10 R17
          out_c = 1'b0;
        end else if (open_drain) begin
          oe_c  = drv_req & ~drv_val;  // R23
          out_c = 1'b0;
        end else begin
          oe_c  = drv_req;  // R12
          out_c = drv_val;
        end
      end

      // Weak pullup on digital open-drain pins, off while driving low.
      assign pu_c = pin_input_mode_mask[p] & open_drain &
                    ~weak_pullup_disable & ~oe_c;  // R14 R15 R10

      // Pin outputs come from flip-flops.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_q <= 1'b0;
          oe_q  <= 1'b0;
          pu_q  <= 1'b0;
        end else begin
          out_q <= out_c;
          oe_q  <= oe_c;
          pu_q  <= pu_c;
        end
      end

      assign pin_out[p]    = out_q;
      assign pin_oe[p]     = oe_q;
      assign pin_pullup[p] = pu_q;
    end
  endgenerate

endmodule

`default_nettype wire

// *** hdl/pcxio_pkg.sv ***
// Constants shared by the priority crossbar and port I/O block.
package pcxio_pkg;

  // Pin and signal counts.
  localparam int NUM_PINS  = 17;
  localparam int XBAR_PINS = 16;
  localparam int NUM_SIGS  = 17;
  localparam int SYNC_LEN  = 3;

  // Peripheral signal indices, listed in crossbar priority order.
  localparam logic [4:0] SIG_TX   = 5'h00;
  localparam logic [4:0] SIG_RX   = 5'h01;
  localparam logic [4:0] SIG_SCK  = 5'h02;
  localparam logic [4:0] SIG_MISO = 5'h03;
  localparam logic [4:0] SIG_MOSI = 5'h04;
  localparam logic [4:0] SIG_NSS  = 5'h05;
  localparam logic [4:0] SIG_SDA  = 5'h06;
  localparam logic [4:0] SIG_SCL  = 5'h07;
  localparam logic [4:0] SIG_CP   = 5'h08;
  localparam logic [4:0] SIG_CPA  = 5'h09;
  localparam logic [4:0] SIG_SYSC = 5'h0A;
  localparam logic [4:0] SIG_COUNTER_MODULE0_IO = 5'h0B;
  localparam logic [4:0] SIG_CEX1 = 5'h0C;
  localparam logic [4:0] SIG_CEX2 = 5'h0D;
  localparam logic [4:0] SIG_ECI  = 5'h0E;
  localparam logic [4:0] SIG_T0   = 5'h0F;
  localparam logic [4:0] SIG_T1   = 5'h10;

  // Fixed pins of the UART.
  localparam int UART_TX_PIN = 4;
  localparam int UART_RX_PIN = 5;

  // Register byte offsets.
  localparam logic [7:0] OFF_ROUTE_A  = 8'h00;
  localparam logic [7:0] OFF_ROUTE_B  = 8'h04;
  localparam logic [7:0] OFF_PORT0    = 8'h08;
  localparam logic [7:0] OFF_PORT1    = 8'h0C;
  localparam logic [7:0] OFF_PORT2    = 8'h10;
  localparam logic [7:0] OFF_P0_INMD  = 8'h14;
  localparam logic [7:0] OFF_P1_INMD  = 8'h18;
  localparam logic [7:0] OFF_P0_OUTMD = 8'h1C;
  localparam logic [7:0] OFF_P1_OUTMD = 8'h20;
  localparam logic [7:0] OFF_P0_SKIP  = 8'h24;
  localparam logic [7:0] OFF_P1_SKIP  = 8'h28;
  localparam logic [7:0] OFF_SPI_MODE = 8'h2C;
  localparam logic [7:0] OFF_P2_MODE  = 8'h30;

  // Field positions in route register A.
  localparam int RA_UART = 0;
  localparam int RA_SPI  = 1;
  localparam int RA_SMB  = 2;
  localparam int RA_SYSC = 3;
  localparam int RA_CP   = 4;
  localparam int RA_CPA  = 5;

  // Field positions in route register B.
  localparam int RB_PCA_LO = 0;
  localparam int RB_ECI    = 3;
  localparam int RB_T0     = 4;
  localparam int RB_T1     = 5;
  localparam int RB_CROSSBAR_ENABLE_BIT  = 6;
  localparam int RB_WPUD   = 7;

  // Field positions in the port 2 mode register.
  localparam int P2_INMD  = 0;
  localparam int P2_OUTMD = 1;

  // Values after reset.
  localparam logic [5:0] RST_ROUTE_A = 6'h00;
  localparam logic [7:0] RST_ROUTE_B = 8'h00;
  localparam logic [7:0] RST_LATCH   = 8'hFF;
  localparam logic [7:0] RST_INMD    = 8'hFF;
  localparam logic [7:0] RST_OUTMD   = 8'h00;
  localparam logic [7:0] RST_SKIP    = 8'h00;
  localparam logic [1:0] RST_SPIMD   = 2'h0;
  localparam logic [1:0] RST_P2MODE  = 2'h1;
  localparam logic [1:0] SPI_3WIRE   = 2'h0;

endpackage

// *** test/pcxio_chk.sv ***
// Port-level assertions for the crossbar and port I/O block.
`timescale 1ns/10ps
`default_nettype none
module pcxio_chk
  import pcxio_pkg::*;
(
  // Clock, reset and register bus.
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Peripheral and pin side.
  input wire logic [NUM_SIGS-1:0] periph_out,
  input wire logic [NUM_SIGS-1:0] periph_drive,
  input wire logic [NUM_SIGS-1:0] periph_in,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] pin_pullup
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // An access outside the register map is refused.
  wire logic bad_a = (paddr > OFF_P2_MODE) || (paddr[1:0] != 2'h0);

  // Bus answers come with no wait states.
  a_ready_access: assert property (psel && penable |-> pready) else $error("pready missing");
  a_ready_idle: assert property (!(psel && penable) |-> !pready) else $error("pready stray");
  a_err_unmapped: assert property (psel && penable && bad_a |-> pslverr)
    else $error("no slave error");
  a_err_mapped: assert property (psel && penable && !bad_a |-> !pslverr)
    else $error("false slave error");
  a_err_rdata: assert property (psel && penable && !pwrite && bad_a |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_rdata_hold: assert property (psel && penable |=> $stable(prdata))
    else $error("read data moved");
  // A pin that is driven never has its pullup on.
  a_drive_nopull: assert property ((pin_oe & pin_pullup) == 17'h00000)
    else $error("pullup on driven pin");
  // After reset the crossbar is off: no drivers, idle peripheral inputs.
  a_rst_quiet: assert property ($rose(presetn) |-> (pin_oe == 17'h00000) [*4])
    else $error("driver on after reset");
  a_rst_idle_in: assert property ($rose(presetn) |-> (periph_in == 17'h1FFFF) [*4])
    else $error("peripheral input not idle");
  a_rst_pullup: assert property ($rose(presetn) |=> pin_pullup == 17'h1FFFF)
    else $error("pullups not on after reset");

  // Main scenarios.
  c_refused: cover property (psel && penable && bad_a);
  c_drive_low: cover property ((pin_oe & ~pin_out) != 17'h00000);
  c_rx_low: cover property (periph_in[SIG_RX] == 1'b0);
endmodule
bind pcxio_top pcxio_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .periph_out(periph_out), .periph_drive(periph_drive),
  .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pullup(pin_pullup));
`default_nettype wire

// *** test/pcxio_pads.sv ***
// Board model of the seventeen pads with outside drivers.
`timescale 1ns/10ps
`default_nettype none
module pcxio_pads (
  // Clock.
  input  wire logic        pclk,
  // Block drive and pullups.
  input  wire logic [16:0] pin_out,
  input  wire logic [16:0] pin_oe,
  input  wire logic [16:0] pin_pullup,
  // Outside drivers.
  input  wire logic [16:0] ext_en,
  input  wire logic [16:0] ext_val,
  // Resolved pad levels.
  output logic      [16:0] pad
);
  logic [16:0] flt_q = 17'h00000;
  // A pad nobody holds wanders, so flip it every cycle.
  always @(posedge pclk) begin
    flt_q <= ~pad;
  end
  // Block drive first, a low from either side winning, then outside drive, then pullup, else wandering.
  always_comb begin
    pad = (pin_oe & pin_out & ~(ext_en & ~ext_val)) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pullup | flt_q));
  end
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench of the crossbar and port I/O block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pcxio_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, err_seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr;
  logic [16:0] periph_out, periph_drive, periph_in, pad, pin_out, pin_oe, pin_pullup;
  logic [16:0] ext_en, ext_val;
  int          mismatches, tests_run;

  pcxio_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_out(periph_out), .periph_drive(periph_drive),
    .periph_in(periph_in), .pin_in(pad), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup));
  pcxio_pads i_pads (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pad(pad));

  // Clock of 10 ns.
  always #5 pclk = ~pclk;

  // Compare one value and count it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One bus transfer: setup, then access until pready.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("ERROR t=%0t no pready on the bus", $time);
    end
    q = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // Let settings reach the pins and pad changes reach the reads.
  task automatic settle;
    repeat (6) @(posedge pclk);
    #1;
  endtask

  task automatic t_reset;
    logic [7:0]  a [10] = '{OFF_ROUTE_A, OFF_ROUTE_B, OFF_P0_INMD, OFF_P1_INMD, OFF_P0_OUTMD,
                           OFF_P1_OUTMD, OFF_P0_SKIP, OFF_P1_SKIP, OFF_SPI_MODE, OFF_P2_MODE};
    logic [31:0] e [10] = '{0, 0, 32'hFF, 32'hFF, 0, 0, 0, 0, 0, 32'h1};
    for (int i = 0; i < 10; i++) begin
      rc(a[i], e[i]);
    end
    rc(OFF_PORT0, 32'hFF);
    rc(8'h34, 32'h0);
    chk(32'(err_seen), 32'h1);
    chk(32'(pin_oe), 32'h0);
    bus(1'b1, OFF_ROUTE_B, 32'h80);
    settle;
    chk(32'(pin_pullup), 32'h0);
    bus(1'b1, OFF_ROUTE_B, 32'h00);
    settle;
    chk(32'(pin_pullup), 32'h1FFFF);
    $display("reset test done");
  endtask

  task automatic t_gpio;
    bus(1'b1, OFF_P0_OUTMD, 32'hFF);
    bus(1'b1, OFF_PORT0, 32'h5A);
    settle;
    chk(32'(pin_oe), 32'h0);
    bus(1'b1, OFF_ROUTE_B, 32'h40);
    settle;
    chk({pin_oe[7:0], pin_out[7:0], pin_pullup[7:0]}, 32'hFF5A00);
    rc(OFF_PORT0, 32'h5A);
    bus(1'b1, OFF_PORT0, 32'hFF);
    $display("gpio test done");
  endtask

  task automatic t_route;
    // Settings go in the safe order: skips, then routes.
    bus(1'b1, OFF_P0_SKIP, 32'h0C);
    bus(1'b1, OFF_ROUTE_A, 32'h07);
    ext_en <= 17'h00020;
    settle;
    chk(32'(pin_oe & ~pin_out), 32'h1D1);
    chk(32'(periph_in[SIG_RX]), 32'h0);
    @(posedge pclk);
    ext_en <= 17'h00000;
    bus(1'b1, OFF_P0_SKIP, 32'h00);
    bus(1'b1, OFF_SPI_MODE, 32'h1);
    bus(1'b1, OFF_ROUTE_A, 32'h17);
    for (int n = 0; n < 4; n++) begin
      bus(1'b1, OFF_ROUTE_B, 32'h40 | n);
      settle;
      chk(32'(pin_oe & ~pin_out), 32'h1D5 | (((1 << n) - 1) << 9));
    end
    @(posedge pclk);
    periph_out <= 17'h00041;
    settle;
    chk({pin_oe[6], pin_pullup[6], pin_oe[4], pin_out[4]}, 32'h7);
    $display("route test done");
  endtask

  task automatic t_analog;
    bus(1'b1, OFF_P0_INMD, 32'h7F);
    bus(1'b1, OFF_P0_SKIP, 32'h80);
    settle;
    chk({pin_oe[7], pin_pullup[7]}, 32'h0);
    bus(1'b0, OFF_PORT0, 32'h0);
    chk(32'(q[7]), 32'h0);
    bus(1'b1, OFF_ROUTE_B, 32'h00);
    settle;
    chk(32'(pin_oe), 32'h0);
    chk(32'(periph_in), 32'h1FFFF);
    $display("analog test done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    periph_out = 17'h00000;
    periph_drive = 17'h03FD5;
    ext_en = 17'h00000;
    ext_val = 17'h00000;
    mismatches = 0;
    tests_run = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_gpio;
    t_route;
    t_analog;
    wrap_up;
  end

  // Watchdog against a hung handshake.
  initial begin
    #200us;
    mismatches++;
    $display("ERROR t=%0t watchdog expired", $time);
    wrap_up;
  end
endmodule
`default_nettype wire
